// ### cnc_core.sv
// file: negate / not / load-one / clip-compare decoder and executor with axi4-lite slave
//
// Contract
// - integer negate is two's complement
// - memory negate decoded from 1001 111t s000 0000
// - register not inverts all 32 bits
// - register not decoded from 0001 1110 zeros
// - load-and-not inverts host word into destination
// - load-and-not decoded from 0101 1110
// - load-one writes one in chosen format
// - clip compare on fixed endpoints sets three flags
// - second-point flag when w2 minus magnitude negative
// - first-point flag when w1 minus magnitude negative
// - flag patterns encode endpoint positions
// - clip opcodes carry no register fields
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
module cnc_core (
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // axi write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // axi write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi read address
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // axi read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    typedef enum logic [1:0] {CNC_IDLE, CNC_EXEC} cnc_state_e;

    logic [63:0]         rf_reg [cnc_pkg::NREGS];
    logic [63:0]         rf_next [cnc_pkg::NREGS];
    logic [31:0]         instr_reg, instr_next;
    logic [31:0]         hw0_reg, hw0_next, hw1_reg, hw1_next;
    logic [4:0]          rsel_reg, rsel_next, wsel_reg, wsel_next;
    logic [31:0]         wdlo_reg, wdlo_next;
    cnc_pkg::cnc_clip_s  flags_reg, flags_next;
    logic                illegal_reg, illegal_next;
    cnc_state_e          st_reg, st_next;
    logic                aw_got_reg, aw_got_next, w_got_reg, w_got_next;
    logic [7:0]          awa_reg, awa_next;
    logic [31:0]         wd_reg, wd_next;
    logic                bvalid_reg, bvalid_next;
    logic [1:0]          bresp_reg, bresp_next;
    logic                rvalid_reg, rvalid_next;
    logic [31:0]         rdata_reg, rdata_next;
    logic [1:0]          rresp_reg, rresp_next;
    cnc_pkg::cnc_dec_s   dec;

    // instruction decode
    function automatic cnc_pkg::cnc_dec_s decode(input logic [31:0] i);
        cnc_pkg::cnc_dec_s d;
        logic [7:0] hi;
        d        = '0;
        d.op     = cnc_pkg::CNC_OP_NONE;
        hi       = {i[15:9], 1'b0};
        d.is_int = ~i[cnc_pkg::F_T];
        d.dbl    = i[cnc_pkg::F_S];
        d.src    = {1'b0, i[cnc_pkg::F_SRC_HI:cnc_pkg::F_SRC_LO]};
        d.dst    = i[cnc_pkg::F_DST_HI:cnc_pkg::F_DST_LO];
        if (i[6:0] == 7'h00) begin
            if (i[24:21] == cnc_pkg::MID_NEG && i[8:7] != 2'b01
                && (hi == cnc_pkg::OP_NEG_REG || hi == cnc_pkg::OP_NEG_LD
                || hi == cnc_pkg::OP_NEG_MEM)) begin
                d.op   = cnc_pkg::CNC_OP_NEG;
                d.load = (hi != cnc_pkg::OP_NEG_REG);
            end else if (i[24:21] == cnc_pkg::MID_NOT && i[8:7] == 2'b00
                && (i[15:8] == cnc_pkg::OP_NOT_REG || i[15:8] == cnc_pkg::OP_NOT_LD
                || i[15:8] == cnc_pkg::OP_NOT_MEM)) begin
                d.op     = cnc_pkg::CNC_OP_NOT;
                d.load   = (i[15:8] != cnc_pkg::OP_NOT_REG);
                d.is_int = 1'b1;
                d.dbl    = 1'b0;
            end else if (i[28:21] == {cnc_pkg::MID_ONE, cnc_pkg::MID_ONE}
                && hi == cnc_pkg::OP_ONE && i[8:7] != 2'b01) begin
                d.op = cnc_pkg::CNC_OP_ONE;
            end else if (i[28:20] == 9'h000 && hi == cnc_pkg::OP_CLIPX
                && i[19:18] == 2'b00 && i[17:16] != 2'b11 && i[8:7] != 2'b01) begin
                d.op   = cnc_pkg::CNC_OP_CLIP;
                d.axis = i[17:16];
            end
        end
        // a negate or not source field of 8 or above is refused
        d.legal = (d.op != cnc_pkg::CNC_OP_NONE)
                  && !((d.op == cnc_pkg::CNC_OP_NEG || d.op == cnc_pkg::CNC_OP_NOT)
                       && i[cnc_pkg::F_SRC_HI]);
        return d;
    endfunction

    // magnitude of a coordinate in the active format
    function automatic logic [63:0] mag(input logic [63:0] v, input logic ii, input logic dd);
        logic [63:0] m;
        m = v;
        if (ii)
            m = v[31] ? {32'h0000_0000, 32'(-v[31:0])} : {32'h0000_0000, v[31:0]};
        else if (dd)
            m = {1'b0, v[62:0]};
        else
            m = {32'h0000_0000, 1'b0, v[30:0]};
        return m;
    endfunction

    // sign of a w minus magnitude difference
    function automatic logic below(input logic [63:0] w, input logic [63:0] c,
                                   input logic ii, input logic dd);
        logic [63:0] m;
        logic        ws;
        logic [62:0] wm;
        logic [62:0] cm;
        m  = mag(c, ii, dd);
        ws = 1'b0;
        wm = '0;
        cm = '0;
        if (ii) begin
            below = $signed(w[31:0]) < $signed(m[31:0]);
        end else begin
            ws = dd ? w[63] : w[31];
            wm = dd ? w[62:0] : {32'h0, w[30:0]};
            cm = m[62:0];
            // floats: w - |c| < 0 if w negative and not both zero, or |w| < |c|
            below = ws ? ((wm | cm) != 63'h0) : (wm < cm);
        end
    endfunction

    function automatic logic sgn(input logic [63:0] v, input logic ii, input logic dd);
        return (dd && !ii) ? v[63] : v[31];
    endfunction

    assign dec = decode(instr_reg);

    // execution and register file
    always_comb begin
        logic [63:0] opnd;
        logic [63:0] res;
        logic        vb;
        logic        nb;
        opnd         = '0;
        res          = '0;
        vb           = 1'b0;
        nb           = 1'b0;
        for (int k = 0; k < cnc_pkg::NREGS; k++) begin
            rf_next[k] = rf_reg[k];
        end
        flags_next   = flags_reg;
        illegal_next = illegal_reg;
        st_next      = st_reg;
        if (aw_got_reg && w_got_reg && !bvalid_reg && awa_reg == cnc_pkg::OFF_WDHI) begin
            rf_next[wsel_reg] = {wd_reg, wdlo_reg};
        end
        unique case (st_reg)
            CNC_IDLE: begin
                if (aw_got_reg && w_got_reg && !bvalid_reg && awa_reg == cnc_pkg::OFF_CTRL
                    && wd_reg[cnc_pkg::CTRL_GO]) begin
                    st_next = CNC_EXEC;
                end
            end
            CNC_EXEC: begin
                st_next      = CNC_IDLE;
                illegal_next = !dec.legal;
                if (dec.legal) begin
                    // a double load pairs host word 0 (high) with word 1 (low)
                    if (dec.load)
                        opnd = dec.dbl ? {hw0_reg, hw1_reg} : {32'h0, hw0_reg};
                    else
                        opnd = rf_reg[dec.src];
                    if (dec.load)
                        rf_next[dec.src] = opnd;
                    unique case (dec.op)
                        cnc_pkg::CNC_OP_NEG: begin
                            if (dec.is_int)
                                res = {32'h0, 32'(-opnd[31:0])};
                            else if (dec.dbl)
                                res = {~opnd[63], opnd[62:0]};
                            else
                                res = {32'h0, ~opnd[31], opnd[30:0]};
                            rf_next[dec.dst] = res;
                        end
                        cnc_pkg::CNC_OP_NOT: begin
                            rf_next[dec.dst] = {32'h0, ~opnd[31:0]};
                        end
                        cnc_pkg::CNC_OP_ONE: begin
                            rf_next[dec.dst] = dec.is_int ? cnc_pkg::ONE_INT
                                             : dec.dbl ? cnc_pkg::ONE_DBL
                                             : cnc_pkg::ONE_SGL;
                        end
                        cnc_pkg::CNC_OP_CLIP: begin
                            // p1 in file a 0..3, p2 in file b 0..3
                            vb = below(rf_reg[cnc_pkg::FILE_B_BASE + 5'd3],
                                       rf_reg[cnc_pkg::FILE_B_BASE + 5'(dec.axis)],
                                       dec.is_int, dec.dbl);
                            nb = below(rf_reg[3], rf_reg[5'(dec.axis)],
                                       dec.is_int, dec.dbl);
                            flags_next.v = vb;
                            flags_next.n = nb;
                            flags_next.z = vb && nb
                                && (sgn(rf_reg[5'(dec.axis)], dec.is_int, dec.dbl)
                                == sgn(rf_reg[cnc_pkg::FILE_B_BASE + 5'(dec.axis)],
                                       dec.is_int, dec.dbl));
                            rf_next[cnc_pkg::REG_FBT] = {63'h0, vb};
                            rf_next[cnc_pkg::REG_FB]  = {63'h0, nb};
                        end
                        default: begin
                        end
                    endcase
                end
            end
        endcase
    end

    // axi4-lite slave
    always_comb begin
        logic wr_fire;
        logic [7:0] a;
        aw_got_next = aw_got_reg;
        w_got_next  = w_got_reg;
        awa_next    = awa_reg;
        wd_next     = wd_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        instr_next  = instr_reg;
        hw0_next    = hw0_reg;
        hw1_next    = hw1_reg;
        rsel_next   = rsel_reg;
        wsel_next   = wsel_reg;
        wdlo_next   = wdlo_reg;
        a           = awa_reg;
        wr_fire     = aw_got_reg && w_got_reg && !bvalid_reg;
        if (awvalid && awready) begin
            aw_got_next = 1'b1;
            awa_next    = awaddr;
        end
        if (wvalid && wready) begin
            w_got_next = 1'b1;
            wd_next    = wdata;
        end
        if (wr_fire) begin
            aw_got_next = 1'b0;
            w_got_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = cnc_pkg::AXI_OKAY;
            unique case (a)
                cnc_pkg::OFF_INSTR:  instr_next = wd_reg;
                cnc_pkg::OFF_HOSTW0: hw0_next   = wd_reg;
                cnc_pkg::OFF_HOSTW1: hw1_next   = wd_reg;
                cnc_pkg::OFF_RSEL:   rsel_next  = wd_reg[4:0];
                cnc_pkg::OFF_WSEL:   wsel_next  = wd_reg[4:0];
                cnc_pkg::OFF_WDLO:   wdlo_next  = wd_reg;
                cnc_pkg::OFF_CTRL, cnc_pkg::OFF_WDHI: begin
                end
                default:             bresp_next = cnc_pkg::AXI_SLVERR;
            endcase
        end else if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_next = 1'b1;
            rresp_next  = cnc_pkg::AXI_OKAY;
            rdata_next  = 32'h0000_0000;
            unique case (araddr)
                cnc_pkg::OFF_INSTR:  rdata_next = instr_reg;
                cnc_pkg::OFF_HOSTW0: rdata_next = hw0_reg;
                cnc_pkg::OFF_HOSTW1: rdata_next = hw1_reg;
                cnc_pkg::OFF_CTRL:   rdata_next = 32'h0000_0000;
                cnc_pkg::OFF_STATUS: rdata_next = {27'h0, illegal_reg, flags_reg.z,
                                                   flags_reg.n, flags_reg.v,
                                                   st_reg != CNC_IDLE};
                cnc_pkg::OFF_RSEL:   rdata_next = {27'h0, rsel_reg};
                cnc_pkg::OFF_RDLO:   rdata_next = rf_reg[rsel_reg][31:0];
                cnc_pkg::OFF_RDHI:   rdata_next = rf_reg[rsel_reg][63:32];
                cnc_pkg::OFF_WSEL:   rdata_next = {27'h0, wsel_reg};
                cnc_pkg::OFF_WDLO:   rdata_next = wdlo_reg;
                cnc_pkg::OFF_WDHI:   rdata_next = 32'h0000_0000;
                default:             rresp_next = cnc_pkg::AXI_SLVERR;
            endcase
        end else if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
    end

    assign awready = !aw_got_reg && !bvalid_reg;
    assign wready  = !w_got_reg && !bvalid_reg;
    assign arready = !rvalid_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < cnc_pkg::NREGS; k++) begin
                rf_reg[k] <= 64'h0;
            end
            instr_reg   <= 32'h0;
            hw0_reg     <= 32'h0;
            hw1_reg     <= 32'h0;
            rsel_reg    <= 5'h0;
            wsel_reg    <= 5'h0;
            wdlo_reg    <= 32'h0;
            flags_reg   <= '0;
            illegal_reg <= 1'b0;
            st_reg      <= CNC_IDLE;
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            awa_reg     <= 8'h0;
            wd_reg      <= 32'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'b00;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= 2'b00;
        end else if (ce) begin
            rf_reg      <= rf_next;
            instr_reg   <= instr_next;
            hw0_reg     <= hw0_next;
            hw1_reg     <= hw1_next;
            rsel_reg    <= rsel_next;
            wsel_reg    <= wsel_next;
            wdlo_reg    <= wdlo_next;
            flags_reg   <= flags_next;
            illegal_reg <= illegal_next;
            st_reg      <= st_next;
            aw_got_reg  <= aw_got_next;
            w_got_reg   <= w_got_next;
            awa_reg     <= awa_next;
            wd_reg      <= wd_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end
endmodule // cnc_core

// ### cnc_pkg.sv
// package: opcodes, register map and carriers for the negate/not/one/clip decoder
package cnc_pkg;
    // axi register byte offsets
    localparam logic [7:0] OFF_INSTR   = 8'h00;
    localparam logic [7:0] OFF_HOSTW0  = 8'h04;
    localparam logic [7:0] OFF_HOSTW1  = 8'h08;
    localparam logic [7:0] OFF_CTRL    = 8'h0C;
    localparam logic [7:0] OFF_STATUS  = 8'h10;
    localparam logic [7:0] OFF_RSEL    = 8'h14;
    localparam logic [7:0] OFF_RDLO    = 8'h18;
    localparam logic [7:0] OFF_RDHI    = 8'h1C;
    localparam logic [7:0] OFF_WSEL    = 8'h20;
    localparam logic [7:0] OFF_WDLO    = 8'h24;
    localparam logic [7:0] OFF_WDHI    = 8'h28;
    // ctrl bits
    localparam int CTRL_GO     = 0;
    localparam int CTRL_HALF1  = 1;
    // status bits
    localparam int ST_BUSY     = 0;
    localparam int ST_CLIP_V   = 1;
    localparam int ST_CLIP_N   = 2;
    localparam int ST_CLIP_Z   = 3;
    localparam int ST_ILLEGAL  = 4;
    // instruction fields
    localparam int F_SRC_HI = 28;
    localparam int F_SRC_LO = 25;
    localparam int F_DST_HI = 20;
    localparam int F_DST_LO = 16;
    localparam int F_T      = 8;
    localparam int F_S      = 7;
    // opcode patterns on bits 15..8 with t masked except for not (t must be 0), low bits 6..0 zero
    localparam logic [7:0] OP_NEG_REG = 8'h1E;   // 0001 111t
    localparam logic [7:0] OP_NEG_LD  = 8'h5E;   // 0101 111t
    localparam logic [7:0] OP_NEG_MEM = 8'h9E;   // 1001 111t
    localparam logic [7:0] OP_NOT_REG = 8'h1E;   // 0001 1110, s=0
    localparam logic [7:0] OP_NOT_LD  = 8'h5E;   // 0101 1110
    localparam logic [7:0] OP_NOT_MEM = 8'h9E;
    localparam logic [7:0] OP_ONE     = 8'h10;   // 0001 000t
    localparam logic [7:0] OP_CLIPX   = 8'h3A;   // 0011 101t
    localparam logic [3:0] MID_NEG    = 4'h3;
    localparam logic [3:0] MID_NOT    = 4'h1;
    localparam logic [3:0] MID_ONE    = 4'hD;
    localparam logic [4:0] MID_ONE_HI = 5'h0D;   // bits 24..21 = 1101 / 1
    localparam logic [9:0] CLIP_X_HI  = 10'h000; // bits 19..16 axis
    localparam logic [3:0] AXIS_X     = 4'h0;
    localparam logic [3:0] AXIS_Y     = 4'h1;
    localparam logic [3:0] AXIS_Z     = 4'h2;
    // register file: 0..9 file a, 16..25 file b, 26 feedback, 27 feedback temp
    localparam logic [4:0] REG_FB     = 5'd26;
    localparam logic [4:0] REG_FBT    = 5'd27;
    localparam int         NREGS      = 28;
    localparam logic [4:0] FILE_B_BASE = 5'd16;
    localparam logic [63:0] ONE_INT   = 64'h0000_0000_0000_0001;
    localparam logic [63:0] ONE_SGL   = 64'h0000_0000_3F80_0000;
    localparam logic [63:0] ONE_DBL   = 64'h3FF0_0000_0000_0000;
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        CNC_OP_NONE, CNC_OP_NEG, CNC_OP_NOT, CNC_OP_ONE, CNC_OP_CLIP
    } cnc_op_e;

    typedef struct packed {
        cnc_op_e     op;
        logic        load;    // operand comes from host words
        logic        is_int;
        logic        dbl;
        logic [4:0]  src;
        logic [4:0]  dst;
        logic [1:0]  axis;
        logic        legal;
    } cnc_dec_s;

    typedef struct packed {
        logic v;
        logic n;
        logic z;
    } cnc_clip_s;
endpackage : cnc_pkg

// ### cnc_core_monitor.sv
// checker: register bus handshakes and clip flag relations at the decoder ports
module cnc_core_monitor (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // write channels
    input wire logic [7:0]  awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    // read channels
    input wire logic [7:0]  araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        rready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] aw_reg;
    logic [7:0] aw_next;
    logic [7:0] ar_reg;
    logic [7:0] ar_next;
    // remember the last accepted addresses to judge the answers
    always_comb begin
        aw_next = (awvalid && awready) ? awaddr : aw_reg;
        ar_next = (arvalid && arready) ? araddr : ar_reg;
    end
    always_ff @(posedge aclk) begin
        aw_reg <= aw_next;
        ar_reg <= ar_next;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_b_due; awvalid && awready && wvalid && wready |-> ##[1:2] bvalid; endproperty
    a_b_due: assert property (p_b_due) else $error("write response late");
    property p_r_due; arvalid && arready |-> ##[1:2] rvalid; endproperty
    a_r_due: assert property (p_r_due) else $error("read data late");
    property p_ar_busy; rvalid |-> !arready; endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("read address taken while busy");
    property p_aw_busy; bvalid |-> !awready && !wready; endproperty
    a_aw_busy: assert property (p_aw_busy) else $error("write taken while response pending");
    property p_b_err; bvalid && aw_reg > 8'h28 |-> bresp == 2'b10; endproperty
    a_b_err: assert property (p_b_err) else $error("unmapped write not refused");
    property p_b_done; bvalid && bready |=> !bvalid; endproperty
    a_b_done: assert property (p_b_done) else $error("write response repeated");
    property p_clip_z; rvalid && ar_reg == 8'h10 && rdata[3] |-> rdata[2] && rdata[1];
    endproperty
    a_clip_z: assert property (p_clip_z) else $error("same-side flag alone");
endmodule // cnc_core_monitor

// ### cnc_host_model.sv
// host model: operand memory and an address register stepping one word per fetch
module cnc_host_model;
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [16];
    logic [31:0] ptr;
    initial begin
        ptr = 32'h0000_0100;
        for (int i = 0; i < 16; i++) mem[i] = 32'h3F00_0000 + 32'h0001_0203 * i;
    end
    task automatic fetch_post(output logic [31:0] w);
        w = mem[ptr[8:5]];
        ptr = ptr + 32'h0000_0020;
    endtask
    task automatic fetch_pre(output logic [31:0] w);
        ptr = ptr - 32'h0000_0020;
        w = mem[ptr[8:5]];
    endtask
endmodule // cnc_host_model

// ### cnc_core_test.sv
// testbench: register bus driven checks of negate, not, load-one and clip compare
module cnc_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, rd, w;
    logic        t, s;
    int          errors = 0;
    int          cmp_count = 0;
    logic [63:0] fv [3] = '{64'h7, 64'h3FC0_0000, 64'hC008_0000_0000_0000};
    logic [63:0] one [3] = '{cnc_pkg::ONE_INT, cnc_pkg::ONE_SGL, cnc_pkg::ONE_DBL};
    logic [31:0] c1 [6] = '{32'h6, 32'h6, 32'h6, 32'h0, 32'h0, 32'hFFFF_FFFC};
    logic [31:0] c2 [6] = '{32'h7, 32'hFFFF_FFF9, 32'h0, 32'hFFFF_FFFB, 32'h0, 32'h4};
    logic [2:0]  znv [6] = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0};
    always #10 aclk = ~aclk;
    cnc_core u_cnc_core (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    cnc_host_model u_cnc_host_model ();
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic sa, sw, sb;
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            sa = awvalid && awready;
            sw = wvalid && wready;
            sb = bvalid === 1'b1;
            resp = bresp;
            n++;
            @(posedge aclk);
            if (sa) awvalid <= 1'b0;
            if (sw) wvalid <= 1'b0;
            if (sb) bready <= 1'b0;
        end while (!sb && n < 100);
        if (!sb) chk(64'h0, 64'h1);
    endtask
    task automatic axr(input logic [7:0] a);
        logic sa, sr;
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            sa = arvalid && arready;
            sr = rvalid === 1'b1;
            rd = rdata;
            resp = rresp;
            n++;
            @(posedge aclk);
            if (sa) arvalid <= 1'b0;
            if (sr) rready <= 1'b0;
        end while (!sr && n < 100);
        if (!sr) chk(64'h0, 64'h1);
    endtask
    task automatic wr_reg(input logic [4:0] i, input logic [63:0] v);
        axw(cnc_pkg::OFF_WSEL, {27'h0, i});
        axw(cnc_pkg::OFF_WDLO, v[31:0]);
        axw(cnc_pkg::OFF_WDHI, v[63:32]);
    endtask
    task automatic ck_reg(input logic [4:0] i, input logic [63:0] e);
        logic [31:0] lo;
        axw(cnc_pkg::OFF_RSEL, {27'h0, i});
        axr(cnc_pkg::OFF_RDLO);
        lo = rd;
        axr(cnc_pkg::OFF_RDHI);
        chk({rd, lo}, e);
    endtask
    task automatic run(input logic [31:0] ins, input logic [31:0] w0, input logic [31:0] w1);
        axw(cnc_pkg::OFF_INSTR, ins);
        axw(cnc_pkg::OFF_HOSTW0, w0);
        axw(cnc_pkg::OFF_HOSTW1, w1);
        axw(cnc_pkg::OFF_CTRL, 32'h0000_0001);
        repeat (3) @(posedge aclk);
    endtask
    // source fields below 8 pick the first operand file
    function automatic logic [31:0] ins(input logic [3:0] sr, input logic [3:0] m,
        input logic [4:0] d, input logic [7:0] op, input logic dbl);
        return {3'h0, sr, m, d, op, dbl, 7'h00};
    endfunction
    function automatic logic [63:0] ngx(input logic tf, input logic sf, input logic [63:0] v);
        if (!tf) return {32'h0, -v[31:0]};
        if (sf) return v ^ 64'h8000_0000_0000_0000;
        return {32'h0, v[31:0] ^ 32'h8000_0000};
    endfunction
    task automatic finish_test;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        errors++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axw(8'h40, 32'h0000_0000);
        chk({62'h0, resp}, {62'h0, cnc_pkg::AXI_SLVERR});
        axr(cnc_pkg::OFF_STATUS);
        chk({32'h0, rd}, 64'h0);
        chk({62'h0, resp}, {62'h0, cnc_pkg::AXI_OKAY});
        for (int f = 0; f < 3; f++) begin
            t = f != 0;
            s = f == 2;
            wr_reg(5'd5, fv[f]);
            run(ins(4'h5, cnc_pkg::MID_NEG, 5'd7, cnc_pkg::OP_NEG_REG | t, s), 0, 0);
            ck_reg(5'd7, ngx(t, s, fv[f]));
            run(ins(4'h2, cnc_pkg::MID_NEG, 5'd17, cnc_pkg::OP_NEG_LD | t, s),
                s ? fv[f][63:32] : fv[f][31:0], fv[f][31:0]);
            ck_reg(5'd2, fv[f]);
            ck_reg(5'd17, ngx(t, s, fv[f]));
            run(ins(4'hD, 4'hD, 5'd4, cnc_pkg::OP_ONE | t, s), 0, 0);
            ck_reg(5'd4, one[f]);
            if (f < 2) begin
                u_cnc_host_model.fetch_post(w);
                run(ins(4'h3, cnc_pkg::MID_NEG, 5'd8, cnc_pkg::OP_NEG_MEM | t, 1'b0), w, w);
                ck_reg(5'd8, ngx(t, 1'b0, {32'h0, w}));
                u_cnc_host_model.fetch_pre(w);
                run(ins(4'h3, cnc_pkg::MID_NEG, 5'd9, cnc_pkg::OP_NEG_MEM | t, 1'b0), w, w);
                ck_reg(5'd9, ngx(t, 1'b0, {32'h0, w}));
            end
        end
        wr_reg(5'd1, 64'h0000_0000_0F0F_A55A);
        run(ins(4'h1, cnc_pkg::MID_NOT, 5'd20, cnc_pkg::OP_NOT_REG, 1'b0), 0, 0);
        ck_reg(5'd20, 64'h0000_0000_F0F0_5AA5);
        run(ins(4'h6, cnc_pkg::MID_NOT, 5'd21, cnc_pkg::OP_NOT_LD, 1'b0),
            32'h1234_5678, 32'h1234_5678);
        ck_reg(5'd6, 64'h0000_0000_1234_5678);
        ck_reg(5'd21, 64'h0000_0000_EDCB_A987);
        u_cnc_host_model.fetch_post(w);
        run(ins(4'h0, cnc_pkg::MID_NOT, 5'd22, cnc_pkg::OP_NOT_MEM, 1'b0), w, w);
        ck_reg(5'd22, {32'h0, ~w});
        u_cnc_host_model.fetch_pre(w);
        run(ins(4'h0, cnc_pkg::MID_NOT, 5'd23, cnc_pkg::OP_NOT_MEM, 1'b0), w, w);
        ck_reg(5'd23, {32'h0, ~w});
        // both endpoint w values are 4; coordinates sit on the tested axis
        wr_reg(5'd3, 64'h4);
        wr_reg(5'd19, 64'h4);
        for (int a = 0; a < 3; a++) begin
            for (int c = 0; c < 6; c++) begin
                wr_reg(5'(a), {32'h0, c1[c]});
                wr_reg(5'(16 + a), {32'h0, c2[c]});
                run(ins(4'h0, 4'h0, 5'(a), cnc_pkg::OP_CLIPX, 1'b0), 0, 0);
                axr(cnc_pkg::OFF_STATUS);
                chk({61'h0, rd[3:1]}, {61'h0, znv[c]});
                ck_reg(cnc_pkg::REG_FBT, {63'h0, znv[c][0]});
            end
        end
        run(ins(4'h8, cnc_pkg::MID_NEG, 5'd7, cnc_pkg::OP_NEG_REG, 1'b0), 0, 0);
        axr(cnc_pkg::OFF_STATUS);
        chk({63'h0, rd[4]}, 64'h1);
        finish_test;
    end
endmodule // cnc_core_test
bind cnc_core cnc_core_monitor u_cnc_core_monitor (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready));
